// ---- logic/bst_pkg.sv ----
// package for the boundary scan test access logic
package bst_pkg;
   localparam int IR_W      = 4;
   localparam int ID_W      = 32;
   localparam int BSR_W     = 8;
   localparam int SYNC_W    = 2;
   // instruction codes
   localparam logic [3:0] IR_EXTEST = 4'h0;
   localparam logic [3:0] IR_SAMPLE = 4'h1;
   localparam logic [3:0] IR_IDCODE = 4'h2;
   localparam logic [3:0] IR_CLAMP  = 4'h3;
   localparam logic [3:0] IR_BYPASS = 4'hF;
   localparam logic [3:0] IR_CAPT   = 4'h1;
   // identification fields, values arbitrary
   localparam logic [3:0]  ID_VERSION = 4'h1;
   localparam logic [15:0] ID_PART    = 16'h1234;
   localparam logic [10:0] ID_MANUF   = 11'h055;
   localparam logic        ID_MARKER  = 1'b1;
   // tap states, one-hot
   typedef enum logic [15:0] {
      ST_TLR  = 16'h0001, ST_RTI  = 16'h0002, ST_SELDR = 16'h0004, ST_CAPDR = 16'h0008,
      ST_SHDR = 16'h0010, ST_EX1DR = 16'h0020, ST_PADR = 16'h0040, ST_EX2DR = 16'h0080,
      ST_UPDR = 16'h0100, ST_SELIR = 16'h0200, ST_CAPIR = 16'h0400, ST_SHIR = 16'h0800,
      ST_EX1IR = 16'h1000, ST_PAIR = 16'h2000, ST_EX2IR = 16'h4000, ST_UPIR = 16'h8000
   } bst_state_type;
   // test pins from the tester
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } bst_pins_type;
   // serial output pin
   typedef struct packed {
      logic tdo;
      logic tdo_oe;
   } bst_tdo_type;
endpackage

// ---- logic/bst_sync.sv ----
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module bst_sync #(
   parameter int W = 3
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   // data
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] s1_q;
   // first stage feeds only the second
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_q <= '0;
         q_o  <= '0;
      end else begin
         s1_q <= d_i;
         q_o  <= s1_q;
      end
   end
endmodule

// ---- logic/bst_tap.sv ----
// boundary scan test access port: tap controller, instruction and data registers
`timescale 1ns/1ps
// Behaviour
// [RULE1] test logic is reached through test mode select, test clock, test reset, data in and data out.
// [RULE2] the decoder carries out bypass, extest, sample, clamp and idcode.
// [RULE3] in normal functional mode the controller sits in test-logic-reset.
// [RULE4] entering test-logic-reset loads idcode as the current instruction.
// [RULE5] a low test reset forces test-logic-reset at once, without the test clock.
// [RULE6] under idcode the 32-bit identification register forms the scan path.
// [RULE7] capture-dr under idcode loads the fixed code, which shift-dr then shifts out.
// [RULE8] the identification register is bits 31 to 0, bit 0 leaving first.
// [RULE9] the code holds manufacturer, part number and version fields.
// [RULE10] under bypass a single-bit register forms the scan path.
// [RULE11] under extest the boundary register drives and observes the pins.
// [RULE12] under sample the boundary register captures the pin inputs without disturbing them.
// [RULE13] under sample data may be shifted in and preloaded into the update latches.
// [RULE14] under clamp bypass is the scan path while the pins are driven from the latches.
// [RULE15] tms and tdi are taken on the rising test clock, tdo changes on the falling one.
// [RULE16] tdo is driven only in shift-ir and shift-dr.
module bst_tap
   import bst_pkg::*;
#(
   parameter int BSR_LEN = bst_pkg::BSR_W
) (
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_n_i,
   // test pins
   input  wire bst_pkg::bst_pins_type pins_i,
   input  wire logic                 trst_n_i,
   output bst_pkg::bst_tdo_type      tdo_o,
   // core pin boundary
   input  wire logic [BSR_LEN-1:0]   core_out_i,
   input  wire logic [BSR_LEN-1:0]   pin_in_i,
   output logic      [BSR_LEN-1:0]   pin_out_o,
   output logic                      test_mode_o
);
   import bst_pkg::*;

   localparam logic [ID_W-1:0] ID_CODE = {ID_VERSION, ID_PART, ID_MANUF, ID_MARKER}; // RULE9

   logic [2:0]          sync_w;
   logic                tck_s;
   logic                tms_s;
   logic                tdi_s;
   logic                tck_d1_q;
   logic                trst_s1_q;
   logic                trst_s2_q;
   bst_state_type       st_q;
   bst_state_type       st_d;
   logic [IR_W-1:0]     ir_sh_q;
   logic [IR_W-1:0]     ir_q;
   logic [ID_W-1:0]     id_q;
   logic                byp_q;
   logic [BSR_LEN-1:0]  bsr_q;
   logic [BSR_LEN-1:0]  upd_q;
   logic [BSR_LEN-1:0]  outv_q;
   logic                tdo_q;
   logic                oe_q;
   logic                tst_q;
   logic [BSR_LEN-1:0]  pin_s;

   // test pins into the system clock, two flops each
   bst_sync #(.W(3)) u_sync ( // RULE1
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     ({pins_i.tck, pins_i.tms, pins_i.tdi}),
      .q_o     (sync_w)
   );

   // pad levels cross into the system clock before capture, no metastable capture
   bst_sync #(.W(BSR_LEN)) u_pin_sync ( // RULE12
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     (pin_in_i),
      .q_o     (pin_s)
   );

   // test clock edges found by the system clock
   assign tck_s = sync_w[2];
   assign tms_s = sync_w[1];
   assign tdi_s = sync_w[0];
   wire tck_rise = tck_s & ~tck_d1_q;   // RULE15
   wire tck_fall = ~tck_s & tck_d1_q;   // RULE15
   wire trst_act = ~trst_s2_q;

   // instruction decoding
   wire sel_id    = (ir_q == IR_IDCODE);                         // RULE6
   wire sel_bsr   = (ir_q == IR_EXTEST) || (ir_q == IR_SAMPLE);
   wire drive_ext = (ir_q == IR_EXTEST) || (ir_q == IR_CLAMP);   // RULE11 RULE14
   wire dr_bit    = sel_id ? id_q[0] : (sel_bsr ? bsr_q[0] : byp_q); // RULE8 RULE10
   wire shifting  = (st_q == ST_SHDR) || (st_q == ST_SHIR);
   wire ser_bit   = (st_q == ST_SHIR) ? ir_sh_q[0] : dr_bit;
   wire [BSR_LEN-1:0] cap_v = pin_s;

   // tap next state on tms
   always_comb begin
      case (st_q)
         ST_TLR:   st_d = tms_s ? ST_TLR   : ST_RTI;
         ST_RTI:   st_d = tms_s ? ST_SELDR : ST_RTI;
         ST_SELDR: st_d = tms_s ? ST_SELIR : ST_CAPDR;
         ST_CAPDR: st_d = tms_s ? ST_EX1DR : ST_SHDR;
         ST_SHDR:  st_d = tms_s ? ST_EX1DR : ST_SHDR;
         ST_EX1DR: st_d = tms_s ? ST_UPDR  : ST_PADR;
         ST_PADR:  st_d = tms_s ? ST_EX2DR : ST_PADR;
         ST_EX2DR: st_d = tms_s ? ST_UPDR  : ST_SHDR;
         ST_UPDR:  st_d = tms_s ? ST_SELDR : ST_RTI;
         ST_SELIR: st_d = tms_s ? ST_TLR   : ST_CAPIR;
         ST_CAPIR: st_d = tms_s ? ST_EX1IR : ST_SHIR;
         ST_SHIR:  st_d = tms_s ? ST_EX1IR : ST_SHIR;
         ST_EX1IR: st_d = tms_s ? ST_UPIR  : ST_PAIR;
         ST_PAIR:  st_d = tms_s ? ST_EX2IR : ST_PAIR;
         ST_EX2IR: st_d = tms_s ? ST_UPIR  : ST_SHIR;
         ST_UPIR:  st_d = tms_s ? ST_SELDR : ST_RTI;
         default:  st_d = ST_TLR;
      endcase
   end

   // previous synchronised test clock, low after reset so no false edge
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tck_d1_q <= 1'b0;
      end else begin
         tck_d1_q <= tck_s; // RULE15
      end
   end

   // test reset pin, asserted at once, released through two flops
   always_ff @(posedge clk_i or negedge trst_n_i) begin
      if (!trst_n_i) begin
         trst_s1_q <= 1'b0;
         trst_s2_q <= 1'b0;
      end else begin
         trst_s1_q <= 1'b1;
         trst_s2_q <= trst_s1_q;
      end
   end

   // tap state, forced asynchronously by test reset
   always_ff @(posedge clk_i or negedge rst_n_i or negedge trst_n_i) begin
      if (!rst_n_i || !trst_n_i) begin
         st_q <= ST_TLR; // RULE5 RULE3
      end else if (trst_act) begin
         st_q <= ST_TLR; // RULE5
      end else if (tck_rise) begin
         st_q <= st_d;
      end
   end

   // instruction register
   always_ff @(posedge clk_i or negedge rst_n_i or negedge trst_n_i) begin
      if (!rst_n_i || !trst_n_i) begin
         ir_sh_q <= IR_CAPT;
         ir_q    <= IR_IDCODE; // RULE4
      end else if (trst_act || st_q == ST_TLR) begin
         ir_q    <= IR_IDCODE; // RULE4
      end else if (tck_rise) begin
         if (st_q == ST_CAPIR) begin
            ir_sh_q <= IR_CAPT;
         end else if (st_q == ST_SHIR) begin
            ir_sh_q <= {tdi_s, ir_sh_q[IR_W-1:1]};
         end else if (st_q == ST_UPIR) begin
            ir_q    <= ir_sh_q; // RULE2
         end
      end
   end

   // data registers: id, bypass, boundary shift stage
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         id_q  <= '0;
         byp_q <= 1'b0;
         bsr_q <= '0;
      end else if (tck_rise) begin
         if (st_q == ST_CAPDR) begin
            id_q  <= ID_CODE; // RULE7
            byp_q <= 1'b0;
            bsr_q <= cap_v;   // RULE12 RULE11
         end else if (st_q == ST_SHDR) begin
            if (sel_id) begin
               id_q <= {tdi_s, id_q[ID_W-1:1]}; // RULE8
            end else if (sel_bsr) begin
               bsr_q <= {tdi_s, bsr_q[BSR_LEN-1:1]}; // RULE13
            end else begin
               byp_q <= tdi_s; // RULE10 RULE14
            end
         end
      end
   end

   // update latches, preloaded under sample or extest
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         upd_q <= '0;
      end else if (tck_rise && st_q == ST_UPDR && sel_bsr) begin
         upd_q <= bsr_q; // RULE13
      end
   end

   // pin drive mux registered
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         outv_q <= '0;
         tst_q  <= 1'b0;
      end else begin
         outv_q <= drive_ext ? upd_q : core_out_i; // RULE11 RULE14 RULE12
         tst_q  <= drive_ext;
      end
   end

   // tdo on the falling test clock
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tdo_q <= 1'b0;
         oe_q  <= 1'b0;
      end else if (trst_act) begin
         oe_q  <= 1'b0;
      end else if (tck_fall) begin
         tdo_q <= ser_bit;  // RULE15
         oe_q  <= shifting; // RULE16
      end
   end

   // outputs
   assign tdo_o.tdo    = tdo_q;
   assign tdo_o.tdo_oe = oe_q;
   assign pin_out_o    = outv_q;
   assign test_mode_o  = tst_q;
endmodule

// ---- sim/bst_tap_props.sv ----
// assertions on the ports of the test access port
`timescale 1ns/1ps
module bst_tap_props
   import bst_pkg::*;
#(parameter int BSR_LEN = 8) (
   // watched ports
   input wire logic               clk_i, rst_n_i, trst_n_i, test_mode_o,
   input wire bst_pins_type       pins_i,
   input wire bst_tdo_type        tdo_o,
   input wire logic [BSR_LEN-1:0] core_out_i, pin_in_i, pin_out_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_reset_quiet: assert property ($rose(rst_n_i) |-> !tdo_o.tdo_oe && !test_mode_o
      && pin_out_o == '0) else $error("outputs active out of reset");
   a_trst_oe: assert property (!trst_n_i |-> ##[0:3] !tdo_o.tdo_oe)
      else $error("tdo driven in test reset");
   a_trst_mode: assert property (!trst_n_i |-> ##[0:4] !test_mode_o)
      else $error("test mode kept in test reset");
   a_func_pins: assert property ($past(rst_n_i) && !test_mode_o && !$past(test_mode_o)
      |-> pin_out_o == $past(core_out_i)) else $error("pins not following core");
   a_test_hold: assert property (test_mode_o && $past(test_mode_o) && $changed(core_out_i)
      |=> $stable(pin_out_o) || !test_mode_o) else $error("core reached pins in test");
   a_tdo_low_phase: assert property (trst_n_i && $past(trst_n_i) && $changed(tdo_o)
      |-> !$past(pins_i.tck, 3)) else $error("tdo moved in high phase");
   a_tdo_after_fall: assert property (trst_n_i && $past(trst_n_i) && $changed(tdo_o)
      |-> $past(pins_i.tck, 4) || $past(pins_i.tck, 5) || $past(pins_i.tck, 6))
      else $error("tdo moved without clock fall");
   a_mode_cause: assert property ($rose(test_mode_o) |-> trst_n_i && $past(trst_n_i))
      else $error("test mode rose in test reset");
endmodule

// ---- sim/bst_tester.sv ----
// tester model driving the test pins
`timescale 1ns/1ps
module bst_tester (
   // test pins
   output logic      tck_o, tms_o, tdi_o,
   input  wire logic tdo_i, oe_i
);
   logic last;
   // released tdo shows the inverse of its last driven level
   always @(tdo_i or oe_i) if (oe_i) last = tdo_i;
   initial tck_o = 0;
   // one test clock, pins change while it is low, clock stops low
   task automatic step(input logic m, d, output logic q);
      tms_o = m;
      tdi_o = d;
      #80 q = oe_i ? tdo_i : ~last;
      tck_o = 1;
      #80 tck_o = 0;
   endtask
   // shift n bits through data or instruction path, back to idle
   task automatic scan(input bit ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic q;
      dout = '0;
      step(1, 0, q);
      if (ir) step(1, 0, q);
      step(0, 0, q);
      step(0, 0, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1, 0, q);
      step(0, 0, q);
   endtask
   // ones into test-logic-reset, then idle
   task automatic reset_tap(input int n);
      logic q;
      repeat (n) step(1, 0, q);
      step(0, 0, q);
   endtask
   initial tms_o = 1;
   initial tdi_o = 0;
endmodule

// ---- sim/tb_top.sv ----
// testbench for the boundary scan test access port
`timescale 1ns/1ps
module tb_top;
   import bst_pkg::*;
   logic             clk_i = 0, rst_n_i = 0, trst_n_i = 0, mode;
   logic [BSR_W-1:0] core = 8'h3C, pin_in = 8'h96, pin_out;
   wire bst_pins_type pins;
   bst_tdo_type      tdo;
   logic [31:0]      r;
   int               n_mismatch = 0, samples_checked = 0, cycles = 0;
   always #10 clk_i = ~clk_i;
   bst_tester bst_tester_inst (.tck_o(pins.tck), .tms_o(pins.tms), .tdi_o(pins.tdi),
      .tdo_i(tdo.tdo), .oe_i(tdo.tdo_oe));
   bst_tap #(.BSR_LEN(BSR_W)) bst_tap_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .pins_i(pins), .trst_n_i(trst_n_i), .tdo_o(tdo), .core_out_i(core),
      .pin_in_i(pin_in), .pin_out_o(pin_out), .test_mode_o(mode));
   task automatic check(input string what, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // hang guard
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 9000) begin
         n_mismatch++;
         summarize();
      end
   end
   task automatic sc(input bit ir, input int n, input logic [31:0] d);
      bst_tester_inst.scan(ir, n, d, r);
   endtask
   task automatic ld(input logic [3:0] op);
      sc(1, 4, {28'h0, op});
      check("ir capture", r, IR_CAPT);
      repeat (6) @(negedge clk_i);
   endtask
   task automatic t_idcode();
      sc(0, 32, 32'h0);
      check("idcode", r, {ID_VERSION, ID_PART, ID_MANUF, ID_MARKER});
      check("tdo idle", tdo.tdo_oe, 0);
   endtask
   task automatic t_bypass();
      ld(IR_BYPASS);
      sc(0, 8, 32'hA5);
      check("bypass path", r, 32'h4A);
   endtask
   task automatic t_sample();
      ld(IR_SAMPLE);
      sc(0, 8, 32'h5A);
      check("sample capture", r, 32'h96);
      check("sample pins", pin_out, core);
   endtask
   task automatic t_extest();
      ld(IR_EXTEST);
      check("preload drive", pin_out, 8'h5A);
      check("extest mode", mode, 1);
      @(negedge clk_i);
      core = 8'hE1;
      pin_in = 8'h71;
      sc(0, 8, 32'hC3);
      check("extest capture", r, 32'h71);
      check("extest drive", pin_out, 8'hC3);
   endtask
   task automatic t_clamp();
      ld(IR_CLAMP);
      sc(0, 8, 32'h0F);
      check("clamp path", r, 32'h1E);
      check("clamp drive", pin_out, 8'hC3);
   endtask
   task automatic t_trst();
      @(negedge clk_i);
      trst_n_i = 0;
      repeat (6) @(negedge clk_i);
      check("trst mode", mode, 0);
      check("trst pins", pin_out, core);
      trst_n_i = 1;
      repeat (6) @(negedge clk_i);
      bst_tester_inst.reset_tap(0);
      t_idcode();
   endtask
   // main sequence
   initial begin
      repeat (10) @(negedge clk_i);
      rst_n_i = 1;
      trst_n_i = 1;
      repeat (6) @(negedge clk_i);
      bst_tester_inst.reset_tap(5);
      t_idcode();
      t_bypass();
      t_sample();
      t_extest();
      t_clamp();
      t_trst();
      summarize();
   end
endmodule
bind bst_tap bst_tap_props #(.BSR_LEN(BSR_LEN)) bst_tap_props_inst (.clk_i(clk_i),
   .rst_n_i(rst_n_i), .trst_n_i(trst_n_i), .test_mode_o(test_mode_o), .pins_i(pins_i),
   .tdo_o(tdo_o), .core_out_i(core_out_i), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o));
